// [pkg/trs_pkg.sv]
// Package for the tape rewind sequencer: register map, fields, timing, states
package trs_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned IDLE_MS         = 12;                  // Quiet time before forward kick
   localparam int unsigned IDLE_CYC        = IDLE_MS * (CLK_HZ / 1000);
   localparam int unsigned FWD_QTR_COUNTS  = 8;                   // Forward kick length
   localparam int unsigned CAP_DIV         = 16;                  // Capstan pulses per reference

   // ****************************************
   // APB register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_SENSE  = 8'h08;

   // Control register fields
   localparam int unsigned CTRL_REWIND_BIT = 0;   // Write 1: rewind command pulse
   localparam int unsigned CTRL_READY_BIT  = 1;   // Drive ready enable
   localparam logic [31:0] CTRL_RESET_VAL  = 32'h0000_0000;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      TRS_IDLE  = 3'b000,
      TRS_FWD   = 3'b001,
      TRS_ACCEL = 3'b010,
      TRS_HIGH  = 3'b011,
      TRS_STEP  = 3'b100,
      TRS_LOW   = 3'b101
   } trs_state_t;

   // Drive outputs travel together
   typedef struct packed {
      logic fwd;           // Capstan forward
      logic bkwd;          // Capstan backward
      logic rewind_cur;    // High power rewind current
      logic step_cur;      // Step-down current
      logic coast;         // Capstan coast
      logic left_feed;     // Left reel feeds column
      logic right_take;    // Right reel takes up slack
      logic hs_field;      // High speed field latch
      logic capstan_polarity_hold_reg;           // Capstan polarity hold register
   } trs_drive_t;

endpackage

// [verilog/trs_sequencer.sv]
// Tape rewind sequencer with APB control and status
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

module trs_sequencer #(
   parameter int unsigned IDLE_CYCLES = trs_pkg::IDLE_CYC,      // Quiet time in cycles
   parameter int unsigned HOLD_CYCLES = 1000                    // Reset hold time to stop
) (
   input  wire logic               pclk,             // 100 MHz clock
   input  wire logic               presetn,          // Async reset, active low
   input  wire logic               psel,             // APB select
   input  wire logic               penable,          // APB enable
   input  wire logic               pwrite,           // APB write
   input  wire logic [7:0]         paddr,            // APB byte address
   input  wire logic [31:0]        pwdata,           // APB write data
   output logic      [31:0]        prdata,           // APB read data
   output logic                    pready,           // APB ready
   output logic                    pslverr,          // APB error
   input  wire logic               unload_rew_btn,   // Unload rewind button
   input  wire logic               load_rew_btn,     // Load rewind button
   input  wire logic               reset_btn,        // Reset pushbutton
   input  wire logic               sustained_motion_line, // Motion active
   input  wire logic               load_point_marker,     // Photocell at load point
   input  wire logic               left_radius_sense,     // Little tape left on left reel
   input  wire logic               left_mid_port,    // Left loop above mid port
   input  wire logic               right_mid_port,   // Right loop below mid port
   input  wire logic               cap_tach,         // Capstan tach (quarter counts)
   input  wire logic               left_tach,        // Squared left reel tach
   input  wire logic               right_tach,       // Squared right reel tach
   input  wire logic               below_normal,     // Capstan below normal velocity
   input  wire logic               col_drive_req,    // Column logic drive request
   input  wire logic               col_coast_req,    // Column logic coast request
   output trs_pkg::trs_drive_t     drive,            // Motor drive bundle
   output logic                    ready_lamp,       // Ready indication
   output logic                    tape_indicate_lamp // Tape indicate indication
);

   // ****************************************
   // Input synchronisers
   // ****************************************
   localparam int unsigned NSYNC = 13;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   logic [NSYNC-1:0] s3_q;
   assign raw = {unload_rew_btn, load_rew_btn, reset_btn, sustained_motion_line,
                 load_point_marker, left_radius_sense, left_mid_port, right_mid_port,
                 cap_tach, left_tach, right_tach, below_normal, col_coast_req};

   // Pins cross into the clock domain; third stage only feeds edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic btn_rew, btn_rst, motion, lpm, radius, lmid, rmid, slow, coast_in;
   logic cap_rise, ltach_rise, rtach_rise, rst_rise, drv_sync_q, drv_s1_q;
   assign btn_rew    = s2_q[12] | s2_q[11];
   assign btn_rst    = s2_q[10];
   assign motion     = s2_q[9];
   assign lpm        = s2_q[8];
   assign radius     = s2_q[7];
   assign lmid       = s2_q[6];
   assign rmid       = s2_q[5];
   assign cap_rise   = s2_q[4] & ~s3_q[4];
   assign ltach_rise = s2_q[3] & ~s3_q[3];
   assign rtach_rise = s2_q[2] & ~s3_q[2];
   assign slow       = s2_q[1];
   assign coast_in   = s2_q[0];
   assign rst_rise   = s2_q[10] & ~s3_q[10];

   // Drive request synchroniser kept apart from the vector above
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_s1_q   <= 1'b0;
         drv_sync_q <= 1'b0;
      end else begin
         drv_s1_q   <= col_drive_req;
         drv_sync_q <= drv_s1_q;
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   logic       ready_en_q;
   logic       cmd_rew_q;
   logic       wr_en;
   logic       drv_grant;
   trs_pkg::trs_state_t state_q, state_d;

   // Column drive request only counts while no coast request stands
   assign drv_grant = drv_sync_q & ~coast_in;

   assign pready  = 1'b1;
   assign wr_en   = psel & penable & pwrite;
   assign pslverr = psel & penable & (paddr != trs_pkg::ADDR_CTRL) &
                    (paddr != trs_pkg::ADDR_STATUS) & (paddr != trs_pkg::ADDR_SENSE);

   // Control register; rewind command is a self-clearing pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_en_q <= trs_pkg::CTRL_RESET_VAL[trs_pkg::CTRL_READY_BIT];
         cmd_rew_q  <= 1'b0;
      end else begin
         cmd_rew_q <= 1'b0;
         if (wr_en && paddr == trs_pkg::ADDR_CTRL) begin
            ready_en_q <= pwdata[trs_pkg::CTRL_READY_BIT];
            cmd_rew_q  <= pwdata[trs_pkg::CTRL_REWIND_BIT];
         end
      end
   end

   // Read data registered at setup so it is stable in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            trs_pkg::ADDR_CTRL:   prdata <= {30'h0000_0000, ready_en_q, 1'b0};
            trs_pkg::ADDR_STATUS: prdata <= {24'h00_0000, ready_lamp, tape_indicate_lamp,
                                             drive.hs_field, drive.capstan_polarity_hold_reg, 1'b0, state_q};
            trs_pkg::ADDR_SENSE:  prdata <= {26'h000_0000, drv_grant, lpm, radius, lmid, rmid,
                                             motion};
            default:              prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // Capstan reference divider and speed compare
   // ****************************************
   logic [3:0] div_q;
   logic       ref_pulse;
   assign ref_pulse = cap_rise && (div_q == 4'(trs_pkg::CAP_DIV - 1));

   // One reference per sixteen capstan pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 4'h0;
      end else if (cap_rise) begin
         div_q <= div_q + 4'h1;
      end
   end

   // Reel faster than capstan if its tach arrives before the next reference
   logic l_seen_q, r_seen_q, l_fast_q, r_fast_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         l_seen_q <= 1'b0;
         r_seen_q <= 1'b0;
         l_fast_q <= 1'b0;
         r_fast_q <= 1'b0;
      end else if (state_q == trs_pkg::TRS_IDLE) begin
         // Stale verdicts from the last rewind must not set the field latch
         l_seen_q <= 1'b0;
         r_seen_q <= 1'b0;
         l_fast_q <= 1'b0;
         r_fast_q <= 1'b0;
      end else if (ref_pulse) begin
         l_fast_q <= l_seen_q | ltach_rise;
         r_fast_q <= r_seen_q | rtach_rise;
         l_seen_q <= 1'b0;
         r_seen_q <= 1'b0;
      end else begin
         l_seen_q <= l_seen_q | ltach_rise;
         r_seen_q <= r_seen_q | rtach_rise;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   logic [$clog2(IDLE_CYCLES+1)-1:0] idle_q;
   logic [3:0]  qtr_q;
   logic [$clog2(HOLD_CYCLES+1)-1:0] hold_q;
   logic        idle_long, start, rst_seen_q, stop_req;
   assign idle_long = (idle_q == IDLE_CYCLES[$bits(idle_q)-1:0]);
   assign start     = cmd_rew_q | (btn_rew & ~ready_lamp);
   assign stop_req  = (rst_rise & rst_seen_q) |
                      (btn_rst && hold_q == HOLD_CYCLES[$bits(hold_q)-1:0]);

   // Quiet time counter saturates at the threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_q <= '0;
      end else if (motion) begin
         idle_q <= '0;
      end else if (!idle_long) begin
         idle_q <= idle_q + 1'b1;
      end
   end

   // Next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         trs_pkg::TRS_IDLE: if (start) begin
            if (idle_long)   state_d = trs_pkg::TRS_FWD;
            else             state_d = trs_pkg::TRS_ACCEL;
         end
         trs_pkg::TRS_FWD: if (cap_rise && qtr_q == 4'(trs_pkg::FWD_QTR_COUNTS - 1)) begin
            state_d = trs_pkg::TRS_ACCEL;
         end
         trs_pkg::TRS_ACCEL: begin
            if (radius)                       state_d = trs_pkg::TRS_LOW;
            else if (l_fast_q && r_fast_q)    state_d = trs_pkg::TRS_HIGH;
         end
         trs_pkg::TRS_HIGH: if (radius || rst_rise) begin
            state_d = trs_pkg::TRS_STEP;
         end
         trs_pkg::TRS_STEP: if (slow) begin
            state_d = trs_pkg::TRS_LOW;
         end
         trs_pkg::TRS_LOW: state_d = trs_pkg::TRS_LOW;
         default: state_d = trs_pkg::TRS_IDLE;
      endcase
      if (state_q != trs_pkg::TRS_IDLE && state_q != trs_pkg::TRS_FWD &&
          (lpm || stop_req)) begin
         state_d = trs_pkg::TRS_IDLE;
      end
   end

   // State, forward quarter counter, reset press tracking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= trs_pkg::TRS_IDLE;
         qtr_q      <= 4'h0;
         rst_seen_q <= 1'b0;
         hold_q     <= '0;
      end else begin
         state_q <= state_d;
         qtr_q   <= (state_q == trs_pkg::TRS_FWD && cap_rise) ? qtr_q + 4'h1 :
                    (state_q == trs_pkg::TRS_FWD) ? qtr_q : 4'h0;
         if (state_q == trs_pkg::TRS_IDLE) begin
            rst_seen_q <= 1'b0;
         end else if (rst_rise) begin
            rst_seen_q <= 1'b1;
         end
         hold_q <= (btn_rst && state_q != trs_pkg::TRS_IDLE &&
                    hold_q != HOLD_CYCLES[$bits(hold_q)-1:0]) ? hold_q + 1'b1 :
                   (btn_rst ? hold_q : '0);
      end
   end

   // ****************************************
   // Indicators
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_lamp         <= 1'b0;
         tape_indicate_lamp <= 1'b0;
      end else if (state_q == trs_pkg::TRS_IDLE && start) begin
         ready_lamp         <= 1'b0;
         tape_indicate_lamp <= 1'b0;
      end else if (state_q != trs_pkg::TRS_IDLE && state_d == trs_pkg::TRS_IDLE && lpm) begin
         ready_lamp         <= 1'b1;
         tape_indicate_lamp <= 1'b1;
      end else if (state_q == trs_pkg::TRS_IDLE) begin
         ready_lamp         <= ready_lamp & ready_en_q;
      end
   end

   // ****************************************
   // Motor drive outputs
   // ****************************************
   logic rewinding, high;
   // Follow the next state so motion and lamps change on the same edge
   assign rewinding = (state_d != trs_pkg::TRS_IDLE) && (state_d != trs_pkg::TRS_FWD);
   assign high      = (state_d == trs_pkg::TRS_HIGH);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive <= '0;
      end else begin
         drive.fwd        <= (state_d == trs_pkg::TRS_FWD);
         drive.bkwd       <= rewinding;
         drive.hs_field   <= high;
         drive.capstan_polarity_hold_reg        <= rewinding & ~high;
         // Reels faster than capstan push rewind current up, else step down
         drive.rewind_cur <= high & l_fast_q & r_fast_q;
         drive.step_cur   <= (high & ~(l_fast_q & r_fast_q)) |
                             ((state_d == trs_pkg::TRS_STEP) & ~(l_fast_q & r_fast_q));
         drive.coast      <= coast_in;
         drive.left_feed  <= rewinding & lmid;
         drive.right_take <= rewinding & rmid;
      end
   end

endmodule

// [tb/trs_transport_model.sv]
// Behavioural tape transport: tachs, left radius sense and load point
`timescale 1ns/1ns
module trs_transport_model #(
   parameter int START_POS = 300, // Capstan counts of tape to rewind
   parameter int SLOW_CYC  = 40   // Cycles without rewind current until capstan is slow
) (
   input  wire logic          pclk,              // Clock
   input  wire logic          presetn,           // Reset, active low
   input  wire logic          mount,             // Reload a full reel
   input  trs_pkg::trs_drive_t drive,            // Motor drive bundle
   output logic               cap_tach,          // Capstan tach
   output logic               left_tach,         // Left reel tach
   output logic               right_tach,        // Right reel tach
   output logic               left_radius_sense, // Little tape left
   output logic               load_point_marker, // Marker under photocell
   output logic               below_normal       // Capstan slow
);
   logic [7:0] div_q; // Motion phase
   int         pos_q; // Tape still to rewind
   int         slow_q; // Cycles since rewind current dropped
   // Capstan coasts down gradually, so step-down lasts a while
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) slow_q <= 0;
      else if (drive.rewind_cur) slow_q <= 0;
      else if (slow_q < SLOW_CYC) slow_q <= slow_q + 1;
   end
   // Tachs stand still unless the capstan drives, so a stopped tape gives no edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
         pos_q <= START_POS;
      end else begin
         if (drive.fwd || drive.bkwd) div_q <= div_q + 8'h01;
         if (mount) pos_q <= START_POS;
         else if (drive.bkwd && div_q[1:0] == 2'h3 && pos_q > 0) pos_q <= pos_q - 1;
      end
   end
   // Reels tick faster than one reference per 16 capstan counts
   assign cap_tach          = div_q[1];
   assign left_tach         = div_q[2];
   assign right_tach        = div_q[2];
   assign left_radius_sense = pos_q < 40;
   assign load_point_marker = pos_q == 0;
   assign below_normal      = slow_q == SLOW_CYC;
endmodule

// [tb/trs_sequencer_properties.sv]
// Port level checker of the rewind sequencer
`timescale 1ns/1ns
module trs_sequencer_properties #(
   parameter int unsigned HOLD_CYCLES = 10 // Reset hold time to stop
) (
   input wire logic          pclk,              // Clock
   input wire logic          presetn,           // Reset, active low
   input wire logic          psel,              // APB select
   input wire logic          penable,           // APB enable
   input wire logic          pwrite,            // APB write
   input wire logic [7:0]    paddr,             // APB address
   input wire logic [31:0]   pwdata,            // APB write data
   input wire logic          pslverr,           // APB error
   input wire logic          reset_btn,         // Reset button
   input wire logic          load_point_marker, // Load point seen
   input wire logic          col_coast_req,     // Coast request
   input trs_pkg::trs_drive_t drive,            // Drive bundle
   input wire logic          ready_lamp,        // Ready lamp
   input wire logic          tape_indicate_lamp // Tape indicate lamp
);
   // ****************************************
   // Helper logic and assertions
   // ****************************************
   logic [15:0] held_q; // Cycles reset button held
   logic        moving; // Capstan in motion
   assign moving = drive.fwd || drive.bkwd;
   // Saturates so that a very long hold still counts as held
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) held_q <= 16'h0000;
      else if (!reset_btn) held_q <= 16'h0000;
      else if (held_q != 16'hFFFF) held_q <= held_q + 16'h0001;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_err_unmapped: assert property (
      psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("bad pslverr");
   a_cmd_starts: assert property (
      psel && penable && pwrite && paddr == 8'h00 && pwdata[0] && !moving && !reset_btn
      && !load_point_marker |-> ##[1:3] moving) else $error("command did not start");
   a_dir_excl: assert property (!(drive.fwd && drive.bkwd)) else $error("both directions");
   a_lamps_off: assert property (
      moving |-> !ready_lamp && !tape_indicate_lamp) else $error("lamp lit in motion");
   a_ready_marker: assert property (
      $rose(ready_lamp) |-> load_point_marker) else $error("ready away from marker");
   a_field_phd: assert property (drive.hs_field |-> !drive.capstan_polarity_hold_reg) else $error("hold reg set");
   a_hold_stops: assert property (
      {16'h0000, held_q} > HOLD_CYCLES + 32'd6 |-> !moving) else $error("held reset still moving");
   a_coast_wins: assert property (
      (col_coast_req && drive.bkwd) [*4] |-> drive.coast) else $error("coast not taken");
   c_field: cover property ($rose(drive.hs_field));
   c_kick: cover property ($rose(drive.fwd));
   c_ready: cover property ($rose(ready_lamp));
endmodule
bind trs_sequencer trs_sequencer_properties #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// [tb/tb.sv]
// Self-checking bench of the rewind sequencer with a transport model
`timescale 1ns/1ns
module tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} trs_row_t;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, e, p, mount;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic unload_rew_btn, load_rew_btn, reset_btn, sustained_motion_line, load_point_marker;
   logic left_radius_sense, left_mid_port, right_mid_port, cap_tach, left_tach, right_tach;
   logic below_normal, col_drive_req, col_coast_req, ready_lamp, tape_indicate_lamp;
   trs_pkg::trs_drive_t drive;
   int failures, checks_done, n, cnt;
   trs_row_t rows[5] = '{'{8'h00, 0, 0}, '{8'h04, 0, 0}, '{8'h08, 0, 0},
                         '{8'h0C, 0, 1}, '{8'hFC, 0, 1}};
   trs_sequencer #(.IDLE_CYCLES(50), .HOLD_CYCLES(10)) dut (.*);
   trs_transport_model u_tape (.*);
   // ****************************************
   // Tasks
   // ****************************************
   always #5 pclk = ~pclk;
   task automatic conclude();
      $display("Counts: compares %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         failures++;
         $display("ERROR at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // Holds the request until pready is seen high at an edge
   // Leading edge keeps back to back calls from touching psel twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
      if (n == 20) begin
         failures++;
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return drive.fwd;
         1: return drive.bkwd;
         2: return drive.hs_field;
         3: return ready_lamp;
         4: return !(drive.fwd || drive.bkwd);
         default: return left_radius_sense;
      endcase
   endfunction
   // Bounded wait; running out counts a mismatch and ends the run
   task automatic await(input int k, input int lim);
      for (cnt = 0; cnt < lim && sig(k) !== 1'b1; cnt++) @(posedge pclk);
      chk(sig(k), 1);
      if (cnt == lim) conclude();
   endtask
   task automatic press(input int b, input int len);
      {reset_btn, load_rew_btn, unload_rew_btn} <= 3'(1 << b);
      repeat (len) @(posedge pclk);
      {reset_btn, load_rew_btn, unload_rew_btn} <= 3'h0;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {presetn, psel, penable, pwrite, mount, unload_rew_btn, load_rew_btn} = 0;
      {reset_btn, sustained_motion_line, left_mid_port, right_mid_port} = 0;
      {col_drive_req, col_coast_req, paddr, pwdata, failures, checks_done} = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(0, rows[i].a, 0);
         chk(r, rows[i].d);
         chk(e, rows[i].e);
      end
      $display("Test registers done");
      repeat (60) @(posedge pclk);
      apb(1, trs_pkg::ADDR_CTRL, 32'h3);
      await(0, 20);
      for (cnt = 0, n = 0; drive.fwd && n < 200; n++) begin
         p = cap_tach;
         @(posedge pclk);
         if (cap_tach && !p) cnt++;
      end
      chk(cnt >= 8 && cnt <= 9, 1);
      await(1, 20);
      apb(0, trs_pkg::ADDR_CTRL, 0);
      chk(r, 32'h2);
      await(2, 1000);
      apb(0, trs_pkg::ADDR_STATUS, 0);
      chk(r[7:0], 8'h23);
      chk({drive.rewind_cur, drive.step_cur}, 2'h2);
      {left_mid_port, right_mid_port, col_drive_req, col_coast_req} <= 4'hF;
      repeat (8) @(posedge pclk);
      chk({drive.left_feed, drive.right_take, drive.coast}, 3'h7);
      apb(0, trs_pkg::ADDR_SENSE, 0);
      chk(r[5], 0);
      {left_mid_port, right_mid_port, col_drive_req, col_coast_req} <= 4'h2;
      repeat (4) @(posedge pclk);
      apb(0, trs_pkg::ADDR_SENSE, 0);
      chk({r[5], drive.coast}, 2'h2);
      {left_mid_port, right_mid_port, col_drive_req, col_coast_req} <= 4'h0;
      await(5, 2000);
      repeat (8) @(posedge pclk);
      apb(0, trs_pkg::ADDR_STATUS, 0);
      chk(r[2:0] inside {trs_pkg::TRS_STEP, trs_pkg::TRS_LOW}, 1);
      await(3, 2000);
      chk(drive.bkwd, 0);
      $display("Test command rewind done");
      mount <= 1'b1;
      sustained_motion_line <= 1'b1;
      @(posedge pclk);
      mount <= 1'b0;
      press(1, 5);
      repeat (10) @(posedge pclk);
      chk(sig(4), 1);
      apb(1, trs_pkg::ADDR_CTRL, 0);
      press(1, 5);
      await(1, 20);
      chk(drive.fwd, 0);
      chk(drive.capstan_polarity_hold_reg, 1);
      await(2, 1000);
      press(2, 5);
      repeat (6) @(posedge pclk);
      apb(0, trs_pkg::ADDR_STATUS, 0);
      chk(r[2:0], trs_pkg::TRS_STEP);
      press(2, 5);
      await(4, 20);
      chk(ready_lamp, 0);
      $display("Test button and reset done");
      mount <= 1'b1;
      press(0, 5);
      mount <= 1'b0;
      await(1, 20);
      press(2, 30);
      chk(sig(4), 1);
      apb(1, trs_pkg::ADDR_CTRL, 32'h1);
      await(1, 20);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({drive, ready_lamp, tape_indicate_lamp}, 0);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, trs_pkg::ADDR_CTRL, 0);
      chk(r, trs_pkg::CTRL_RESET_VAL);
      $display("Test hold and mid-run reset done");
      conclude();
   end
endmodule
